/* src/cwrc_top.sv */
// Clock selection, dividers, oscillator control, watchdog and reset-cause record
// Summary of operation
// RULE1: Source changes never glitch the delivered root clock
// RULE2: Asynchronous inputs pass three-stage synchronisers
// RULE3: Four sources: crystal, main, low-power, external
// RULE4: Divided clocks are enables aligned to root
// RULE5: Sixteen 16-bit dividers; twelve fixed, four programmable; here all sixteen are programmable
// RULE6: Analog divider edge precedes digital divider edges
// RULE7: Main oscillator 24 MHz reset, 3-48 range
// RULE8: Trim loaded from storage, rewritable while running
// RULE9: Low-power edges measured against main oscillator
// RULE10: Watchdog on low clock gives reset or interrupt
// RULE11: Watchdog reset sets watchdog cause bit
// RULE12: Software, watchdog, pin reset requests, asynchronous assertion
// RULE13: Reset cause survives the reset it reports
// RULE14: Dedicated active-low pin requests external reset
// RULE15: Service write restarts the watchdog count
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module cwrc_top (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire cwrc_pkg::cwrc_bus_req_type bus_i,
	output logic [31:0] rdata_o,
	input wire logic main_internal_osc_i,
	input wire logic lowpower_internal_osc_i,
	input wire logic crystal_32k_osc_i,
	input wire logic ext_clk_i,
	input wire logic external_reset_pin_n_i,
	input wire logic [cwrc_pkg::TRIM_W-1:0] trim_nvm_i,
	output logic high_freq_root_clock_o,
	output logic [cwrc_pkg::NUM_DIV-1:0] div_en_o,
	output logic [5:0] main_osc_freq_o,
	output logic [cwrc_pkg::TRIM_W-1:0] main_osc_trim_o,
	output logic system_reset_o,
	output logic irq_o
);
	import cwrc_pkg::*;

	logic [NUM_SRC-1:0] src_raw;
	logic [NUM_SRC-1:0] sync1_r;
	logic [NUM_SRC-1:0] sync2_r;
	logic [NUM_SRC-1:0] sync3_r;
	logic [NUM_SRC-1:0] filt_r;
	logic [NUM_SRC-1:0] filt_d_r;
	logic [NUM_SRC-1:0] src_rise;
	logic pin1_r, pin2_r, pin3_r, pin_filt_n_r, pin_d_n_r;
	logic [1:0] sel_req_r, sel_act_r;
	cwrc_sw_state_type sw_state_r;
	logic root_r, root_d_r, root_rise;
	logic [DIV_W-1:0] div_val_r [NUM_DIV];
	logic [DIV_W-1:0] div_cnt_r [NUM_DIV];
	logic [NUM_DIV-1:0] div_hit;
	logic [NUM_DIV-1:0] div_stage_r;
	logic [5:0] freq_r;
	logic [TRIM_W-1:0] trim_r;
	logic trim_loaded_r;
	logic [15:0] wdt_timeout_r, wdt_cnt_r;
	logic wdt_en_r, wdt_mode_rst_r, wdt_expire;
	logic cal_busy_r;
	logic [7:0] cal_lf_r;
	logic [CAL_W-1:0] cal_cnt_r, cal_res_r;
	logic [IRQ_W-1:0] int_st_r, int_mask_r, int_set;
	logic [CAUSE_W-1:0] cause_r;
	logic [3:0] rst_cnt_r;
	logic rst_busy_r, sys_rst_s, sw_rst_req;
	logic wr_sel, rd_sel;
	logic [31:0] rd_val;

	assign src_raw = {ext_clk_i, crystal_32k_osc_i, lowpower_internal_osc_i, main_internal_osc_i};
	assign wr_sel = bus_i.wr;
	assign rd_sel = bus_i.rd;

	// Three-stage synchronisers; a level change counts once stages two and three agree
	generate
		for (genvar s = 0; s < NUM_SRC; s++)
		begin : g_sync
			always_ff @(posedge clock_i or posedge rst_i)
			begin
				if (rst_i)
				begin
					sync1_r[s] <= 1'b0;
					sync2_r[s] <= 1'b0;
					sync3_r[s] <= 1'b0;
					filt_r[s] <= 1'b0;
					filt_d_r[s] <= 1'b0;
				end
				else
				begin
					sync1_r[s] <= src_raw[s]; // [RULE2]
					sync2_r[s] <= sync1_r[s];
					sync3_r[s] <= sync2_r[s];
					if (sync2_r[s] == sync3_r[s])
						filt_r[s] <= sync3_r[s]; // [RULE2]
					filt_d_r[s] <= filt_r[s];
				end
			end
			assign src_rise[s] = filt_r[s] & ~filt_d_r[s];
		end
	endgenerate

	// Reset pin synchroniser: records the cause, reinitialises config and holds system reset until release
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			pin1_r <= 1'b1;
			pin2_r <= 1'b1;
			pin3_r <= 1'b1;
			pin_filt_n_r <= 1'b1;
			pin_d_n_r <= 1'b1;
		end
		else
		begin
			pin1_r <= external_reset_pin_n_i; // [RULE14]
			pin2_r <= pin1_r;
			pin3_r <= pin2_r;
			if (pin2_r == pin3_r)
				pin_filt_n_r <= pin3_r;
			pin_d_n_r <= pin_filt_n_r;
		end
	end

	// Software and watchdog requests are stretched to a fixed reset pulse
	assign sw_rst_req = wr_sel && bus_i.addr == OFS_SW_RESET && bus_i.wdata[0];
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			rst_cnt_r <= 4'h0;
			rst_busy_r <= 1'b0;
		end
		else if (sw_rst_req || (wdt_expire && wdt_mode_rst_r))
		begin
			rst_cnt_r <= RST_CNT_LOAD; // [RULE12]
			rst_busy_r <= 1'b1;
		end
		else if (rst_cnt_r != 4'h0)
			rst_cnt_r <= rst_cnt_r - 4'h1;
		else
			rst_busy_r <= 1'b0;
	end
	assign sys_rst_s = rst_busy_r | ~pin_filt_n_r;
	// Pin path is combinational so the reset asserts even with no clock running
	// Also held until the filtered pin releases, so the chip never leaves reset before this block
	assign system_reset_o = rst_i | sys_rst_s | ~external_reset_pin_n_i; // [RULE12] [RULE14]

	// Reset cause: cleared only by power-on reset or write-one, never by system reset
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			cause_r <= '0;
		else
		begin
			cause_r <= (cause_r & ~((wr_sel && bus_i.addr == OFS_RST_CAUSE) ?
				bus_i.wdata[CAUSE_W-1:0] : '0))
				| {~pin_filt_n_r & pin_d_n_r, wdt_expire & wdt_mode_rst_r, sw_rst_req}; // [RULE11] [RULE13]
		end
	end

	// Configuration registers, returned to defaults by any system reset
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			sel_req_r <= SRC_MAIN;
			freq_r <= OSC_FREQ_RST;
			wdt_timeout_r <= WDT_TIMEOUT_RST;
			wdt_en_r <= 1'b0;
			wdt_mode_rst_r <= 1'b0;
			int_mask_r <= '0;
		end
		else if (sys_rst_s)
		begin
			sel_req_r <= SRC_MAIN;
			freq_r <= OSC_FREQ_RST; // [RULE7]
			wdt_timeout_r <= WDT_TIMEOUT_RST;
			wdt_en_r <= 1'b0;
			wdt_mode_rst_r <= 1'b0;
			int_mask_r <= '0;
		end
		else if (wr_sel)
		begin
			case (bus_i.addr)
				OFS_CLK_SEL: sel_req_r <= bus_i.wdata[1:0]; // [RULE3]
				OFS_OSC_FREQ:
				begin
					// Out-of-range codes are clamped, the oscillator never leaves its band
					if (bus_i.wdata[5:0] < OSC_FREQ_MIN || bus_i.wdata[31:6] != '0)
						freq_r <= (bus_i.wdata[31:6] != '0) ? OSC_FREQ_MAX : OSC_FREQ_MIN; // [RULE7]
					else if (bus_i.wdata[5:0] > OSC_FREQ_MAX)
						freq_r <= OSC_FREQ_MAX;
					else
						freq_r <= bus_i.wdata[5:0]; // [RULE7]
				end
				OFS_WDT_TIMEOUT: wdt_timeout_r <= bus_i.wdata[15:0];
				OFS_WDT_CTRL:
				begin
					wdt_en_r <= bus_i.wdata[WDT_EN_BIT];
					wdt_mode_rst_r <= bus_i.wdata[WDT_MODE_BIT];
				end
				OFS_INT_MASK: int_mask_r <= bus_i.wdata[IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	// Trim: taken from storage after each reset release, then software may overwrite it
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			trim_r <= '0;
			trim_loaded_r <= 1'b0;
		end
		else if (sys_rst_s)
			trim_loaded_r <= 1'b0;
		else if (!trim_loaded_r)
		begin
			trim_r <= trim_nvm_i; // [RULE8]
			trim_loaded_r <= 1'b1;
		end
		else if (wr_sel && bus_i.addr == OFS_OSC_TRIM)
			trim_r <= bus_i.wdata[TRIM_W-1:0]; // [RULE8]
	end
	assign main_osc_freq_o = freq_r;
	assign main_osc_trim_o = trim_r;

	// Glitch-free switch: park output low, wait for new source low, then follow it
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			sw_state_r <= SW_RUN;
			sel_act_r <= SRC_MAIN;
			root_r <= 1'b0;
		end
		else
		begin
			case (sw_state_r)
				SW_RUN:
				begin
					root_r <= filt_r[sel_act_r];
					if (sel_req_r != sel_act_r)
						sw_state_r <= SW_DRAIN;
				end
				SW_DRAIN:
				begin
					// Let the old high phase finish so no phase is cut short
					if (!filt_r[sel_act_r])
					begin
						root_r <= 1'b0; // [RULE1]
						sel_act_r <= sel_req_r;
						sw_state_r <= SW_ARM;
					end
					else
						root_r <= 1'b1;
				end
				SW_ARM:
				begin
					root_r <= 1'b0;
					if (!filt_r[sel_act_r])
						sw_state_r <= SW_RUN; // [RULE1]
				end
				default:
				begin
					sw_state_r <= SW_RUN;
					root_r <= 1'b0;
				end
			endcase
		end
	end
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			root_d_r <= 1'b0;
		else
			root_d_r <= root_r;
	end
	assign root_rise = root_r & ~root_d_r;
	assign high_freq_root_clock_o = root_r;

	// Dividers: each gives one enable per (value+1) root edges, on a root edge
	generate
		for (genvar d = 0; d < NUM_DIV; d++)
		begin : g_div
			assign div_hit[d] = root_rise && div_cnt_r[d] == div_val_r[d]; // [RULE4]
			always_ff @(posedge clock_i or posedge rst_i)
			begin
				if (rst_i)
				begin
					div_val_r[d] <= '0;
					div_cnt_r[d] <= '0;
					div_stage_r[d] <= 1'b0;
				end
				else
				begin
					if (sys_rst_s)
						div_val_r[d] <= '0;
					else if (wr_sel && bus_i.addr == OFS_DIV_BASE + 8'(d * 4))
						div_val_r[d] <= bus_i.wdata[DIV_W-1:0]; // [RULE5]
					if (sys_rst_s)
						div_cnt_r[d] <= '0;
					else if (div_hit[d])
						div_cnt_r[d] <= '0;
					else if (root_rise)
						div_cnt_r[d] <= div_cnt_r[d] + 16'h0001; // [RULE4]
					div_stage_r[d] <= div_hit[d];
				end
			end
			// Analog enable leaves one cycle before each digital enable from the same root edge
			if (d == ANALOG_DIV)
			begin : g_ana
				assign div_en_o[d] = div_stage_r[d]; // [RULE6]
			end
			else
			begin : g_dig
				logic late_r;
				always_ff @(posedge clock_i or posedge rst_i)
				begin
					if (rst_i)
						late_r <= 1'b0;
					else
						late_r <= div_stage_r[d]; // [RULE6]
				end
				assign div_en_o[d] = late_r;
			end
		end
	endgenerate

	// Watchdog counts low-power edges; no sleep input gates it, so it runs in sleep
	assign wdt_expire = wdt_en_r && src_rise[SRC_LP] && wdt_cnt_r == wdt_timeout_r; // [RULE10]
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			wdt_cnt_r <= '0;
		else if (sys_rst_s || !wdt_en_r)
			wdt_cnt_r <= '0;
		else if (wr_sel && bus_i.addr == OFS_WDT_SERVICE)
			wdt_cnt_r <= '0; // [RULE15]
		else if (wdt_expire)
			wdt_cnt_r <= '0;
		else if (src_rise[SRC_LP])
			wdt_cnt_r <= wdt_cnt_r + 16'h0001; // [RULE10]
	end

	// Calibration counts main oscillator edges over a window of low-power edges
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			cal_busy_r <= 1'b0;
			cal_lf_r <= '0;
			cal_cnt_r <= '0;
			cal_res_r <= '0;
		end
		else if (!cal_busy_r)
		begin
			if (wr_sel && bus_i.addr == OFS_CAL && bus_i.wdata[0])
			begin
				cal_busy_r <= 1'b1;
				cal_lf_r <= '0;
				cal_cnt_r <= '0;
			end
		end
		else
		begin
			if (src_rise[SRC_MAIN])
				cal_cnt_r <= cal_cnt_r + 24'h000001; // [RULE9]
			if (src_rise[SRC_LP])
				cal_lf_r <= cal_lf_r + 8'h01;
			if (src_rise[SRC_LP] && cal_lf_r == CAL_LF_EDGES - 8'h01)
			begin
				cal_busy_r <= 1'b0;
				cal_res_r <= cal_cnt_r; // [RULE9]
			end
		end
	end

	// Sticky interrupt status; a new event wins over a same-cycle clear
	assign int_set[IRQ_WDT] = wdt_expire & ~wdt_mode_rst_r; // [RULE10]
	assign int_set[IRQ_CAL] = cal_busy_r && src_rise[SRC_LP] && cal_lf_r == CAL_LF_EDGES - 8'h01;
	assign int_set[IRQ_SW] = sw_state_r == SW_ARM && !filt_r[sel_act_r];
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			int_st_r <= '0;
		else
			int_st_r <= (int_st_r & ~((wr_sel && bus_i.addr == OFS_INT_STATUS) ?
				bus_i.wdata[IRQ_W-1:0] : '0)) | int_set;
	end
	assign irq_o = |(int_st_r & int_mask_r);

	// Read multiplexer; unmapped offsets read as zero
	always_comb
	begin
		rd_val = 32'h00000000;
		case (bus_i.addr)
			OFS_CLK_SEL: rd_val = {30'h0, sel_req_r};
			OFS_OSC_FREQ: rd_val = {26'h0, freq_r};
			OFS_OSC_TRIM: rd_val = {24'h0, trim_r};
			OFS_WDT_TIMEOUT: rd_val = {16'h0, wdt_timeout_r};
			OFS_WDT_CTRL: rd_val = {30'h0, wdt_mode_rst_r, wdt_en_r};
			OFS_WDT_SERVICE: rd_val = {16'h0, wdt_cnt_r};
			OFS_RST_CAUSE: rd_val = {29'h0, cause_r};
			OFS_INT_STATUS: rd_val = {29'h0, int_st_r};
			OFS_INT_MASK: rd_val = {29'h0, int_mask_r};
			OFS_CAL: rd_val = {cal_res_r, 7'h0, cal_busy_r};
			OFS_STATUS: rd_val = {27'h0, sw_state_r, sel_act_r};
			default:
				if (bus_i.addr >= OFS_DIV_BASE && bus_i.addr <= OFS_DIV_END && bus_i.addr[1:0] == 2'h0)
					rd_val = {16'h0, div_val_r[bus_i.addr[5:2]]};
		endcase
	end
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			rdata_o <= '0;
		else
			rdata_o <= rd_sel ? rd_val : 32'h00000000;
	end

	// Checks
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);
	sequence s_drain_done;
		sw_state_r == SW_DRAIN && !filt_r[sel_act_r];
	endsequence
	AST_SWITCH_PARKS_LOW: assert property (s_drain_done |=> !root_r [*2]) // [RULE1]
		else $error("root clock not parked low during switch");
	// The filter makes every high phase at least two cycles, so the root may not drop at once
	AST_NO_RUNT_HIGH: assert property ($rose(root_r) |=> root_r) // [RULE1]
		else $error("root clock high phase cut short");
	// Checked per source: one channel settling must not excuse another
	AST_SYNC_AGREE: assert property (((filt_r ^ $past(filt_r)) // [RULE2]
		& $past(sync2_r ^ sync3_r)) == '0)
		else $error("source level taken before stages agreed");
	AST_DIV_ON_ROOT: assert property (div_en_o[NUM_DIV-1] |-> $past(root_rise, 2)) // [RULE4]
		else $error("digital enable not aligned to a root edge");
	AST_ANALOG_LEADS: assert property (div_en_o[ANALOG_DIV] && div_val_r[1] == div_val_r[0]
		&& div_cnt_r[1] == div_cnt_r[0] |-> ##1 div_en_o[1]) // [RULE6]
		else $error("digital enable not one cycle after analog");
	AST_FREQ_RANGE: assert property (freq_r >= OSC_FREQ_MIN && freq_r <= OSC_FREQ_MAX) // [RULE7]
		else $error("main oscillator code out of range");
	AST_TRIM_LOAD: assert property ($rose(trim_loaded_r) |-> trim_r == $past(trim_nvm_i)) // [RULE8]
		else $error("trim not loaded from storage");
	AST_WDT_SERVICE: assert property (wr_sel && bus_i.addr == OFS_WDT_SERVICE && !sys_rst_s
		|=> wdt_cnt_r == 16'h0000) // [RULE15]
		else $error("service did not restart watchdog");
	AST_WDT_RESET: assert property (wdt_expire && wdt_mode_rst_r |=> rst_busy_r && cause_r[CAUSE_WDT]
		##1 system_reset_o) // [RULE10] [RULE11]
		else $error("watchdog reset not issued or recorded");
	AST_CAUSE_STICKY: assert property (cause_r[CAUSE_SW] && !(wr_sel && bus_i.addr == OFS_RST_CAUSE)
		|=> cause_r[CAUSE_SW]) // [RULE13]
		else $error("reset cause lost");
	AST_SW_RESET: assert property (sw_rst_req |=> system_reset_o [*8]) // [RULE12]
		else $error("software reset pulse too short");
endmodule : cwrc_top
`default_nettype wire

/* src/cwrc_pkg.sv */
// Constants, register map and carrier types of the clock, watchdog and reset-cause block
package cwrc_pkg;
	// Timing
	localparam int CLK_PERIOD_PS = 25000;
	localparam int RST_PULSE_NS = 200;
	localparam int RST_PULSE_CYC = (RST_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam logic [3:0] RST_CNT_LOAD = 4'(RST_PULSE_CYC - 1);
	// Structure
	localparam int NUM_SRC = 4;
	localparam int NUM_DIV = 16;
	localparam int NUM_FIXED_DIV = 12;
	localparam int DIV_W = 16;
	localparam int ANALOG_DIV = 0;
	// Clock source encodings
	localparam logic [1:0] SRC_MAIN = 2'h0;
	localparam logic [1:0] SRC_LP = 2'h1;
	localparam logic [1:0] SRC_XTAL = 2'h2;
	localparam logic [1:0] SRC_EXT = 2'h3;
	// Main oscillator frequency code in MHz
	localparam logic [5:0] OSC_FREQ_RST = 6'h18;
	localparam logic [5:0] OSC_FREQ_MIN = 6'h03;
	localparam logic [5:0] OSC_FREQ_MAX = 6'h30;
	localparam int TRIM_W = 8;
	// Watchdog
	localparam logic [15:0] WDT_TIMEOUT_RST = 16'h1000;
	localparam int WDT_EN_BIT = 0;
	localparam int WDT_MODE_BIT = 1;
	// Calibration window in low-power oscillator edges
	localparam logic [7:0] CAL_LF_EDGES = 8'h08;
	localparam int CAL_W = 24;
	// Interrupt and reset-cause bits
	localparam int IRQ_WDT = 0;
	localparam int IRQ_CAL = 1;
	localparam int IRQ_SW = 2;
	localparam int IRQ_W = 3;
	localparam int CAUSE_SW = 0;
	localparam int CAUSE_WDT = 1;
	localparam int CAUSE_PIN = 2;
	localparam int CAUSE_W = 3;
	// Register byte offsets
	localparam logic [7:0] OFS_CLK_SEL = 8'h00;
	localparam logic [7:0] OFS_OSC_FREQ = 8'h04;
	localparam logic [7:0] OFS_OSC_TRIM = 8'h08;
	localparam logic [7:0] OFS_WDT_TIMEOUT = 8'h0C;
	localparam logic [7:0] OFS_WDT_CTRL = 8'h10;
	localparam logic [7:0] OFS_WDT_SERVICE = 8'h14;
	localparam logic [7:0] OFS_RST_CAUSE = 8'h18;
	localparam logic [7:0] OFS_SW_RESET = 8'h1C;
	localparam logic [7:0] OFS_INT_STATUS = 8'h20;
	localparam logic [7:0] OFS_INT_MASK = 8'h24;
	localparam logic [7:0] OFS_CAL = 8'h28;
	localparam logic [7:0] OFS_STATUS = 8'h2C;
	localparam logic [7:0] OFS_DIV_BASE = 8'h40;
	localparam logic [7:0] OFS_DIV_END = 8'h7C;
	// Register bus request
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} cwrc_bus_req_type;
	// Glitch-free switch states
	typedef enum logic [2:0] {
		SW_RUN = 3'b001,
		SW_DRAIN = 3'b010,
		SW_ARM = 3'b100
	} cwrc_sw_state_type;
endpackage : cwrc_pkg

/* tb/cwrc_far_model.sv */
// Oscillator sources, reset pin driver and divided-clock consumer
`timescale 1ns/1ps
`default_nettype none
module cwrc_far_model (
	input wire logic clock_i,
	input wire logic pin_req_i,
	input wire logic clr_i,
	input wire logic [15:0] div_en_i,
	output logic [3:0] osc_o,
	output logic external_reset_pin_n_o,
	output logic [15:0][7:0] div_hits_o
);
	// Half periods in system cycles: main, low-power, crystal, external
	localparam int HALF [4] = '{3, 5, 7, 4};
	int cnt [4] = '{0, 0, 0, 0};
	logic [3:0] osc_r = 4'h0;
	assign osc_o = osc_r;
	// Free-running sources, each at its own rate
	always @(posedge clock_i)
	begin
		for (int i = 0; i < 4; i++)
		begin
			cnt[i] <= (cnt[i] == HALF[i] - 1) ? 0 : cnt[i] + 1;
			if (cnt[i] == HALF[i] - 1)
				osc_r[i] <= ~osc_r[i];
		end
	end
	// Dedicated pin, pulled low only while a reset is wanted
	assign external_reset_pin_n_o = ~pin_req_i;
	// Consumer side: tally enables per divider for the bench
	always @(posedge clock_i)
	begin
		for (int i = 0; i < 16; i++)
			div_hits_o[i] <= clr_i ? 8'h00 : div_hits_o[i] + 8'(div_en_i[i]);
	end
endmodule : cwrc_far_model
`default_nettype wire

/* tb/clock_watchdog_reset_cause_tb.sv */
// Self-checking bench for the clock, watchdog and reset-cause block
`timescale 1ns/1ps
`default_nettype none
module clock_watchdog_reset_cause_tb;
	import cwrc_pkg::*;
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	cwrc_bus_req_type bus = '0;
	logic pin_req = 1'b0;
	logic clr = 1'b0;
	logic mon_en = 1'b0;
	logic root_d = 1'b0;
	logic [7:0] trim_nvm = 8'h00;
	logic [31:0] rdata;
	logic [31:0] v;
	logic [31:0] w;
	logic [3:0] osc;
	logic pin_n, root, sys_rst, irq;
	logic [15:0] div_en;
	logic [5:0] freq;
	logic [7:0] trim;
	logic [15:0][7:0] hits;
	logic [31:0] corner [6] = '{32'h0, 32'h2, 32'h3, 32'h30, 32'h31, 32'hC8};
	int bad_count = 0;
	int n_compared = 0;
	int hi_run = 0;
	int min_hi = 99;
	int since = 0;
	int a_off = 0;
	int d_off = 0;
	int n;

	// 40 MHz system clock
	always #12.5 clock_i = ~clock_i;

	cwrc_top cwrc_top_inst (.clock_i(clock_i), .rst_i(rst_i), .bus_i(bus), .rdata_o(rdata),
		.main_internal_osc_i(osc[0]), .lowpower_internal_osc_i(osc[1]),
		.crystal_32k_osc_i(osc[2]), .ext_clk_i(osc[3]), .external_reset_pin_n_i(pin_n),
		.trim_nvm_i(trim_nvm), .high_freq_root_clock_o(root), .div_en_o(div_en),
		.main_osc_freq_o(freq), .main_osc_trim_o(trim), .system_reset_o(sys_rst),
		.irq_o(irq));
	cwrc_far_model cwrc_far_model_inst (.clock_i(clock_i), .pin_req_i(pin_req), .clr_i(clr),
		.div_en_i(div_en), .osc_o(osc), .external_reset_pin_n_o(pin_n), .div_hits_o(hits));

	// Root high-phase lengths and divider offsets from the last root rise;
	// the first partial phase after enabling is pushed negative so it never counts
	always @(posedge clock_i)
	begin
		root_d <= root;
		since <= (root === 1'b1 && root_d === 1'b0) ? 0 : since + 1;
		if (div_en[0] === 1'b1)
			a_off <= since;
		if (div_en[5] === 1'b1)
			d_off <= since;
		if (!mon_en)
			hi_run <= -99;
		else if (root === 1'b1)
			hi_run <= hi_run + 1;
		else
		begin
			if (hi_run > 0 && hi_run < min_hi)
				min_hi <= hi_run;
			hi_run <= 0;
		end
	end

	// Expected frequency code: writes are clamped into the legal range
	function automatic logic [5:0] exp_freq(input logic [31:0] x);
		return (x < 32'h3) ? OSC_FREQ_MIN : (x > 32'h30) ? OSC_FREQ_MAX : x[5:0];
	endfunction : exp_freq

	task automatic print_verdict();
		$display("Compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : print_verdict

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		n_compared++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[FAIL] %0t %s: seen %h expected %h", $time, msg, seen, exp);
		end
	endtask : chk

	// One-cycle strobes, driven just after the edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_i);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clock_i);
		bus.wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clock_i);
		bus <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge clock_i);
		bus.rd <= 1'b0;
		#1 d = rdata;
	endtask : rd

	// Polls a register until the masked bits match, with a bound
	task automatic wait_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] x;
		for (int i = 0; i < 400; i++)
		begin
			rd(a, x);
			if ((x & m) === e)
				return;
		end
		chk(x & m, e, "register wait timed out");
		print_verdict();
	endtask : wait_reg

	task automatic wait_rst(input logic want);
		#1;
		for (int i = 0; i < 200 && sys_rst !== want; i++)
			@(posedge clock_i) #1;
		chk(32'(sys_rst), 32'(want), "system reset wait");
		if (sys_rst !== want)
			print_verdict();
	endtask : wait_rst

	// Main sequence
	initial
	begin
		void'($urandom(45954));
		trim_nvm <= 8'($urandom);
		repeat (8) @(posedge clock_i);
		rst_i <= 1'b0;
		@(posedge clock_i) #1;
		chk(32'(freq), 32'(OSC_FREQ_RST), "freq at reset");
		chk(32'(trim), 32'(trim_nvm), "trim load");
		rd(OFS_WDT_TIMEOUT, v);
		chk(v, 32'(WDT_TIMEOUT_RST), "timeout at reset");
		rd(8'h3C, v);
		chk(v, 32'h0, "unmapped read");
		rd(OFS_OSC_FREQ, v);
		@(posedge clock_i) #1;
		chk(rdata, 32'h0, "read data held too long");
		$display("Test reset values done");
		// Frequency codes: corners first, then random
		for (int i = 0; i < 16; i++)
		begin
			w = (i < 6) ? corner[i] : $urandom_range(63);
			wr(OFS_OSC_FREQ, w);
			#1 chk(32'(freq), 32'(exp_freq(w)), "freq output");
			rd(OFS_OSC_FREQ, v);
			chk(v, 32'(exp_freq(w)), "freq readback");
			w = $urandom_range(255);
			wr(OFS_OSC_TRIM, w);
			#1 chk(32'(trim), w, "trim rewrite");
		end
		$display("Test oscillator control done");
		// Every divider at divide-by-two from the main source
		for (int i = 0; i < NUM_DIV; i++)
			wr(8'(OFS_DIV_BASE + 4 * i), 32'h1);
		clr <= 1'b1;
		@(posedge clock_i) clr <= 1'b0;
		repeat (1200) @(posedge clock_i);
		#1;
		for (int i = 0; i < NUM_DIV; i++)
			chk(32'(hits[i] >= 8'h63 && hits[i] <= 8'h65), 32'h1, "divider rate");
		chk(32'(a_off < d_off), 32'h1, "analog edge not first");
		$display("Test dividers done");
		// Walk through every source and back, with the switch event interrupt
		wr(OFS_INT_MASK, 32'h4);
		mon_en <= 1'b1;
		for (int s = 1; s < 5; s++)
		begin
			wr(OFS_CLK_SEL, 32'(s % 4));
			wait_reg(OFS_INT_STATUS, 32'h4, 32'h4);
			rd(OFS_STATUS, v);
			chk(v, 32'({SW_RUN, 2'(s % 4)}), "active source");
			chk(32'(irq), 32'h1, "switch irq");
			wr(OFS_INT_MASK, 32'h0);
			#1 chk(32'(irq), 32'h0, "irq masked");
			wr(OFS_INT_MASK, 32'h4);
			wr(OFS_INT_STATUS, 32'h4);
			#1 chk(32'(irq), 32'h0, "irq cleared");
		end
		mon_en <= 1'b0;
		chk(32'(min_hi >= 3), 32'h1, "runt on root clock");
		$display("Test clock switching done");
		// Watchdog serviced in time, then left to expire
		wr(OFS_WDT_TIMEOUT, 32'h3);
		wr(OFS_INT_MASK, 32'h1);
		wr(OFS_WDT_CTRL, 32'h1);
		for (int i = 0; i < 6; i++)
		begin
			repeat (22) @(posedge clock_i);
			wr(OFS_WDT_SERVICE, 32'h0);
			rd(OFS_INT_STATUS, v);
			chk(v & 32'h1, 32'h0, "expiry despite service");
			rd(OFS_WDT_SERVICE, v);
			chk(32'(v <= 32'h1), 32'h1, "count not restarted");
		end
		wait_reg(OFS_INT_STATUS, 32'h1, 32'h1);
		chk(32'(irq), 32'h1, "watchdog irq");
		wr(OFS_WDT_CTRL, 32'h0);
		wr(OFS_INT_STATUS, 32'h7);
		wr(OFS_RST_CAUSE, 32'h7);
		wr(OFS_OSC_FREQ, 32'hA);
		wr(OFS_WDT_CTRL, 32'h3);
		wait_rst(1'b1);
		wait_rst(1'b0);
		rd(OFS_RST_CAUSE, v);
		chk(v, 32'h2, "watchdog cause");
		chk(32'(freq), 32'(OSC_FREQ_RST), "config after reset");
		$display("Test watchdog done");
		// Software reset: pulse length, cause bit, write-one clear
		wr(OFS_RST_CAUSE, 32'h7);
		wr(OFS_OSC_FREQ, 32'h14);
		wr(OFS_SW_RESET, 32'h1);
		wait_rst(1'b1);
		n = 0;
		while (sys_rst === 1'b1 && n < 20)
		begin
			n++;
			@(posedge clock_i) #1;
		end
		chk(32'(n), 32'h8, "reset pulse length");
		chk(32'(freq), 32'(OSC_FREQ_RST), "config after reset");
		rd(OFS_RST_CAUSE, v);
		chk(v, 32'h1, "software cause");
		wr(OFS_RST_CAUSE, 32'h1);
		rd(OFS_RST_CAUSE, v);
		chk(v, 32'h0, "cause clear");
		$display("Test software reset done");
		// Pin reset acts at once and is recorded
		@(posedge clock_i) pin_req <= 1'b1;
		#1 chk(32'(sys_rst), 32'h1, "pin reset");
		repeat (10) @(posedge clock_i);
		pin_req <= 1'b0;
		wait_rst(1'b0);
		rd(OFS_RST_CAUSE, v);
		chk(v, 32'h4, "pin cause");
		$display("Test pin reset done");
		// Low-power edges measured against the main source
		wr(OFS_INT_STATUS, 32'h7);
		wr(OFS_INT_MASK, 32'h2);
		wr(OFS_CAL, 32'h1);
		wait_reg(OFS_INT_STATUS, 32'h2, 32'h2);
		chk(32'(irq), 32'h1, "calibration irq");
		rd(OFS_CAL, v);
		chk(32'(v[31:8] >= 24'hB && v[31:8] <= 24'hE && !v[0]), 32'h1, "cal count");
		$display("Test calibration done");
		print_verdict();
	end
endmodule : clock_watchdog_reset_cause_tb
`default_nettype wire
